/* File: core/osw_pkg.sv */
// package for the oscillator select and switch control block
// assumes a 32-bit AXI4-Lite register bus and static fuse configuration inputs
package osw_pkg;

   // register byte offsets
   localparam logic [3:0] OSW_OFS_OSC_CTRL = 4'h0;
   localparam logic [3:0] OSW_OFS_UNLOCK = 4'h4;
   localparam logic [3:0] OSW_OFS_CLK_DIV = 4'h8;
   localparam logic [3:0] OSW_OFS_CFG_STAT = 4'hc;

   // oscillator control field positions
   localparam int OSW_CUR_LSB = 12;
   localparam int OSW_REQ_LSB = 8;
   localparam int OSW_SEL_LOCK_BIT = 7;
   localparam int OSW_PIN_LOCK_BIT = 6;
   localparam int OSW_PLL_LOCK_BIT = 5;
   localparam int OSW_FAIL_BIT = 3;
   localparam int OSW_PRI_SLEEP_BIT = 2;
   localparam int OSW_SEC_EN_BIT = 1;
   localparam int OSW_SWITCH_BIT = 0;
   // clock divider register: divider source select
   localparam int OSW_DIV_SRC_LSB = 8;

   // unlock keys, written back to back to the unlock register
   localparam logic [15:0] OSW_KEY_FIRST = 16'h0046;
   localparam logic [15:0] OSW_KEY_SECOND = 16'h0057;

   // reset values
   localparam logic [2:0] OSW_RST_SRC = 3'h7;
   localparam logic [2:0] OSW_RST_DIV_SRC = 3'h0;
   // cycles after reset release before the synchronised fuses are loaded
   localparam logic [1:0] OSW_BOOT_CYCLES = 2'h3;

   localparam logic [1:0] OSW_RESP_OKAY = 2'h0;
   localparam logic [1:0] OSW_RESP_DECERR = 2'h3;

   // oscillator source encodings
   typedef enum logic [2:0] {
      OSW_FAST_INTERNAL_RC = 3'h0,
      OSW_FAST_RC_WITH_PLL = 3'h1,
      OSW_PRIMARY_OSC = 3'h2,
      OSW_PRIMARY_OSC_PLL = 3'h3,
      OSW_SECONDARY_OSC = 3'h4,
      OSW_LOW_POWER_RC = 3'h5,
      OSW_DIGITALLY_TUNED_OSC = 3'h6,
      OSW_DIVIDED_OSC_MODE = 3'h7
   } osw_src_t;

   // nonvolatile configuration fields
   typedef struct packed {
      logic [1:0] switch_monitor_cfg;
      logic [2:0] initial_osc_cfg;
      logic [1:0] primary_driver_mode_cfg;
      logic osc_pin_function_cfg;
      logic pin_lock_one_way_cfg;
   } osw_cfg_t;

   // controls toward the clock tree
   typedef struct packed {
      logic [2:0] current_source;
      logic [2:0] requested_source;
      logic switch_busy;
      logic [2:0] divider_source_select;
      logic failsafe_clock_monitor;
      logic pin_config_lock;
      logic primary_sleep_enable;
      logic secondary_osc_enable;
      logic osc_pin_function;
      logic [1:0] primary_driver_mode;
   } osw_ctrl_t;

endpackage : osw_pkg

/* File: core/osw_osc_switch.sv */
// oscillator source selection and clock switch control with an AXI4-Lite slave
// assumes the clock mux, PLL and fail monitor sit outside and answer on async pins
//
// Summary of operation
// RL1: run-time switching allowed only when switch/monitor config upper bit is zero.
// RL2: fail-safe clock monitor active only when both config bits are zero.
// RL3: read-only current-source field reports running oscillator, eight-value encoding.
// RL4: writable requested-source field at bits 10:8, same encoding.
// RL5: current and requested source load from initial-oscillator config after reset.
// RL6: erased device starts in divided-oscillator mode, code 111.
// RL7: divided mode input chosen by divider source select, fast RC after reset.
// RL8: primary modes take driver mode from primary driver mode config.
// RL9: internal and secondary modes set oscillator pin function from config bit.
// RL10: oscillator control writes need a preceding unlock, blocking accidental switches.
// RL11: with monitor enabled, selection lock bit 7 freezes source selections.
// RL12: with monitor disabled, selections are never locked.
// RL13: pin config lock bit 6 changes only after the unlock sequence.
// RL14: one-way config set means pin config lock cannot clear once set.
// RL15: PLL lock bit 5 reads one when locked, zero otherwise.
// RL16: PLL lock bit forced zero during switch and in non-PLL modes.
// RL17: bits 15, 11 and 4 ignore writes and read zero.
// RL18: software can only clear the clock-fail flag, never set it.
// RL19: hardware sets the clock-fail flag when the monitor sees a failure.
// RL20: switch request bit 0 starts a switch, hardware clears it on completion.
// RL21: primary sleep enable bit 2 keeps primary oscillator running in sleep.
// RL22: secondary enable bit 1 turns the 32 kHz secondary oscillator on.
// RL23: request while switching disabled or locked is ignored, current source unchanged.
// RL24: on completion current source takes requested source as request clears.
`timescale 1ns/1ps
module osw_osc_switch (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // fuse configuration
   input wire osw_pkg::osw_cfg_t cfg_i,
   // clock tree feedback, asynchronous
   input wire logic switch_done_i,
   input wire logic pll_locked_i,
   input wire logic clock_fail_i,
   // clock tree controls
   output osw_pkg::osw_ctrl_t ctrl_o,
   // axi4-lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import osw_pkg::*;

   // synchronisers: first stage feeds only the second
   osw_cfg_t cfg_s1_r;
   osw_cfg_t cfg_r;
   logic [2:0] pin_s1_r;
   logic [2:0] pin_s2_r;
   logic done_d_r;
   logic fail_d_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_s1_r <= '0;
         cfg_r <= '0;
         pin_s1_r <= 3'h0;
         pin_s2_r <= 3'h0;
         done_d_r <= 1'b0;
         fail_d_r <= 1'b0;
      end else begin
         cfg_s1_r <= cfg_i;
         cfg_r <= cfg_s1_r;
         pin_s1_r <= {clock_fail_i, pll_locked_i, switch_done_i};
         pin_s2_r <= pin_s1_r;
         done_d_r <= pin_s2_r[0];
         fail_d_r <= pin_s2_r[2];
      end
   end

   logic done_rise;
   logic fail_rise;
   logic pll_locked_s;
   assign done_rise = pin_s2_r[0] & ~done_d_r;
   assign fail_rise = pin_s2_r[2] & ~fail_d_r;
   assign pll_locked_s = pin_s2_r[1];

   // fuse capture after reset release; async reset may only load constants
   logic [1:0] boot_cnt_r;
   logic boot_load;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         boot_cnt_r <= 2'h0;
      end else if (boot_cnt_r != OSW_BOOT_CYCLES) begin
         boot_cnt_r <= boot_cnt_r + 2'h1;
      end
   end
   assign boot_load = (boot_cnt_r == (OSW_BOOT_CYCLES - 2'h1));

   logic switch_en;
   logic failsafe_clock_monitor_en;
   assign switch_en = ~cfg_r.switch_monitor_cfg[1]; // [RL1]
   assign failsafe_clock_monitor_en = (cfg_r.switch_monitor_cfg == 2'b00); // [RL2]

   // axi4-lite write channel capture, address and data in either order
   logic aw_held_r;
   logic w_held_r;
   logic [3:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_fire;
   logic wr_hit;

   assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
   assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
   assign wr_hit = (aw_addr_r == OSW_OFS_OSC_CTRL) | (aw_addr_r == OSW_OFS_UNLOCK) |
                   (aw_addr_r == OSW_OFS_CLK_DIV) | (aw_addr_r == OSW_OFS_CFG_STAT);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 4'h0;
      end else if (s_axi_awvalid & s_axi_awready) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
      end else if (s_axi_wvalid & s_axi_wready) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= OSW_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? OSW_RESP_OKAY : OSW_RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // write decode; bits 15, 11 and 4 have no storage at all [RL17]
   logic wr_ctrl_lo;
   logic wr_ctrl_hi;
   logic wr_unlock;
   logic wr_div;
   assign wr_ctrl_lo = wr_fire & (aw_addr_r == OSW_OFS_OSC_CTRL) & w_strb_r[0];
   assign wr_ctrl_hi = wr_fire & (aw_addr_r == OSW_OFS_OSC_CTRL) & w_strb_r[1];
   assign wr_unlock = wr_fire & (aw_addr_r == OSW_OFS_UNLOCK) & (w_strb_r[1:0] == 2'b11);
   assign wr_div = wr_fire & (aw_addr_r == OSW_OFS_CLK_DIV) & w_strb_r[1];

   // unlock: two keys back to back, opens the next bus write only
   logic key_armed_r;
   logic unlocked_r;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         key_armed_r <= 1'b0;
         unlocked_r <= 1'b0;
      end else if (wr_fire) begin
         key_armed_r <= wr_unlock & (w_data_r[15:0] == OSW_KEY_FIRST);
         unlocked_r <= wr_unlock & key_armed_r & (w_data_r[15:0] == OSW_KEY_SECOND); // [RL10]
      end
   end

   logic ctrl_wr_lo;
   logic ctrl_wr_hi;
   assign ctrl_wr_lo = wr_ctrl_lo & unlocked_r; // [RL10] [RL13]
   assign ctrl_wr_hi = wr_ctrl_hi & unlocked_r; // [RL10]

   // oscillator control state
   logic [2:0] cur_src_r;
   logic [2:0] req_src_r;
   logic sel_lock_r;
   logic pin_lock_r;
   logic fail_flag_r;
   logic pri_sleep_r;
   logic sec_en_r;
   logic switch_r;
   logic sel_frozen;

   assign sel_frozen = failsafe_clock_monitor_en & sel_lock_r; // [RL11] [RL12]

   // selection lock: sticky while the monitor guards it, free otherwise
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sel_lock_r <= 1'b0;
      end else if (ctrl_wr_lo & ~sel_frozen) begin
         sel_lock_r <= w_data_r[OSW_SEL_LOCK_BIT]; // [RL11]
      end
   end

   // requested source
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         req_src_r <= OSW_RST_SRC; // [RL6]
      end else if (boot_load) begin
         req_src_r <= cfg_r.initial_osc_cfg; // [RL5]
      end else if (ctrl_wr_hi & ~sel_frozen & ~switch_r) begin
         req_src_r <= w_data_r[OSW_REQ_LSB +: 3]; // [RL4] [RL11]
      end
   end

   // switch request and current source; they change on the same edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         switch_r <= 1'b0;
      end else if (boot_load) begin
         switch_r <= 1'b0;
      end else if (switch_r & done_rise) begin
         switch_r <= 1'b0; // [RL20] [RL24]
      end else if (ctrl_wr_lo & w_data_r[OSW_SWITCH_BIT] & switch_en & ~sel_frozen) begin
         switch_r <= 1'b1; // [RL1] [RL20] [RL23]
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cur_src_r <= OSW_RST_SRC; // [RL6]
      end else if (boot_load) begin
         cur_src_r <= cfg_r.initial_osc_cfg; // [RL5]
      end else if (switch_r & done_rise) begin
         cur_src_r <= req_src_r; // [RL24]
      end
   end

   // pin configuration lock
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_lock_r <= 1'b0;
      end else if (ctrl_wr_lo) begin
         if (!(cfg_r.pin_lock_one_way_cfg && pin_lock_r)) begin
            pin_lock_r <= w_data_r[OSW_PIN_LOCK_BIT]; // [RL13] [RL14]
         end
      end
   end

   // clock-fail flag: hardware set beats a software clear in the same cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fail_flag_r <= 1'b0;
      end else if (failsafe_clock_monitor_en & fail_rise) begin
         fail_flag_r <= 1'b1; // [RL19]
      end else if (ctrl_wr_lo & ~w_data_r[OSW_FAIL_BIT]) begin
         fail_flag_r <= 1'b0; // [RL18]
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pri_sleep_r <= 1'b0;
         sec_en_r <= 1'b0;
      end else if (ctrl_wr_lo) begin
         pri_sleep_r <= w_data_r[OSW_PRI_SLEEP_BIT]; // [RL21]
         sec_en_r <= w_data_r[OSW_SEC_EN_BIT]; // [RL22]
      end
   end

   // divider source select, not guarded by the unlock
   logic [2:0] div_src_r;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_src_r <= OSW_RST_DIV_SRC; // [RL7]
      end else if (wr_div) begin
         div_src_r <= w_data_r[OSW_DIV_SRC_LSB +: 3]; // [RL7]
      end
   end

   // PLL lock status, registered to keep a clean readback
   logic pll_mode;
   logic pll_lock_r;
   assign pll_mode = (cur_src_r == OSW_FAST_RC_WITH_PLL) | (cur_src_r == OSW_PRIMARY_OSC_PLL);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pll_lock_r <= 1'b0;
      end else begin
         pll_lock_r <= pll_locked_s & pll_mode & ~switch_r; // [RL15] [RL16]
      end
   end

   // register images
   logic [15:0] ctrl_img;
   logic [15:0] stat_img;
   always_comb begin
      ctrl_img = 16'h0000; // [RL17]
      ctrl_img[OSW_CUR_LSB +: 3] = cur_src_r; // [RL3]
      ctrl_img[OSW_REQ_LSB +: 3] = req_src_r;
      ctrl_img[OSW_SEL_LOCK_BIT] = sel_lock_r;
      ctrl_img[OSW_PIN_LOCK_BIT] = pin_lock_r;
      ctrl_img[OSW_PLL_LOCK_BIT] = pll_lock_r;
      ctrl_img[OSW_FAIL_BIT] = fail_flag_r;
      ctrl_img[OSW_PRI_SLEEP_BIT] = pri_sleep_r;
      ctrl_img[OSW_SEC_EN_BIT] = sec_en_r;
      ctrl_img[OSW_SWITCH_BIT] = switch_r;
   end
   assign stat_img = {4'h0, unlocked_r, failsafe_clock_monitor_en, switch_en, cfg_r};

   // axi4-lite read channel, one-cycle answer
   logic [31:0] rd_word;
   logic rd_hit;
   always_comb begin
      rd_word = 32'h0;
      rd_hit = 1'b1;
      unique case ({s_axi_araddr[3:2], 2'b00})
         OSW_OFS_OSC_CTRL: rd_word = {16'h0000, ctrl_img};
         OSW_OFS_UNLOCK: rd_word = 32'h0;
         OSW_OFS_CLK_DIV: rd_word = {21'h0, div_src_r, 8'h00};
         OSW_OFS_CFG_STAT: rd_word = {16'h0000, stat_img};
         default: rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= OSW_RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? OSW_RESP_OKAY : OSW_RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // clock tree controls, all from flops
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_o <= '0;
      end else begin
         ctrl_o.current_source <= cur_src_r;
         ctrl_o.requested_source <= req_src_r;
         ctrl_o.switch_busy <= switch_r;
         ctrl_o.divider_source_select <= div_src_r; // [RL7]
         ctrl_o.failsafe_clock_monitor <= failsafe_clock_monitor_en; // [RL2]
         ctrl_o.pin_config_lock <= pin_lock_r;
         ctrl_o.primary_sleep_enable <= pri_sleep_r; // [RL21]
         ctrl_o.secondary_osc_enable <= sec_en_r; // [RL22]
         ctrl_o.osc_pin_function <= cfg_r.osc_pin_function_cfg; // [RL9]
         ctrl_o.primary_driver_mode <= cfg_r.primary_driver_mode_cfg; // [RL8]
      end
   end

endmodule : osw_osc_switch

/* File: testbench/osw_osc_switch_chk.sv */
// assertions for the oscillator switch block
// assumes a bind onto osw_osc_switch; sees its ports only
`timescale 1ns/1ps
module osw_osc_switch_chk (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // fuses and feedback
   input wire osw_pkg::osw_cfg_t cfg_i,
   input wire logic switch_done_i,
   // clock tree controls
   input wire osw_pkg::osw_ctrl_t ctrl_o,
   // bus handshakes
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   import osw_pkg::*;
   logic [3:0] up_r;
   logic settled;
   // fuses pass a synchroniser, so config checks wait a few cycles
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         up_r <= 4'h0;
      end else if (up_r != 4'hf) begin
         up_r <= up_r + 4'h1;
      end
   end
   assign settled = (up_r > 4'h6);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence s_done_seen;
      ctrl_o.switch_busy && $rose(switch_done_i);
   endsequence
   property p_done_clears;
      s_done_seen |-> ##[1:8] !ctrl_o.switch_busy;
   endproperty
   a_done_clears: assert property (p_done_clears) else $error("switch not finished");
   property p_failsafe_clock_monitor_cfg;
      settled |-> ctrl_o.failsafe_clock_monitor == (cfg_i.switch_monitor_cfg == 2'h0);
   endproperty
   a_failsafe_clock_monitor_cfg: assert property (p_failsafe_clock_monitor_cfg) else $error("monitor enable wrong");
   property p_busy_allowed;
      $rose(ctrl_o.switch_busy) |-> !cfg_i.switch_monitor_cfg[1];
   endproperty
   a_busy_allowed: assert property (p_busy_allowed) else $error("switch while disabled");
   property p_cur_on_done;
      settled && $changed(ctrl_o.current_source) |-> $past(ctrl_o.switch_busy) && !ctrl_o.switch_busy
         && ctrl_o.current_source == $past(ctrl_o.requested_source);
   endproperty
   a_cur_on_done: assert property (p_cur_on_done) else $error("current source moved wrongly");
   property p_req_frozen;
      ctrl_o.switch_busy && $past(ctrl_o.switch_busy) |-> $stable(ctrl_o.requested_source);
   endproperty
   a_req_frozen: assert property (p_req_frozen) else $error("request moved in switch");
   property p_one_way;
      $fell(ctrl_o.pin_config_lock) |-> !cfg_i.pin_lock_one_way_cfg;
   endproperty
   a_one_way: assert property (p_one_way) else $error("pin lock cleared");
   property p_ar_to_r;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_ar_to_r: assert property (p_ar_to_r) else $error("read answer late");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
   property p_b_once;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_once: assert property (p_b_once) else $error("write answer repeated");
endmodule : osw_osc_switch_chk

/* File: testbench/osw_osc_switch_test.sv */
// self-checking bench for the oscillator switch block over AXI4-Lite
// assumes osw_pkg and osw_osc_switch compiled first; fuses change only in reset
`timescale 1ns/1ps
module osw_osc_switch_test;
   import osw_pkg::*;
   logic clk, reset, switch_done_i, pll_locked_i, clock_fail_i;
   osw_cfg_t cfg_i;
   osw_ctrl_t ctrl_o;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int err_total, checked, cyc;

   osw_osc_switch i_dut (.clk(clk), .reset(reset), .cfg_i(cfg_i), .switch_done_i(switch_done_i),
      .pll_locked_i(pll_locked_i), .clock_fail_i(clock_fail_i), .ctrl_o(ctrl_o),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // both channels offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, OSW_RESP_OKAY});
   endtask : wr

   task automatic rc(input string what, input logic [3:0] a, input logic [15:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk(what, s_axi_rdata, {16'h0, e});
   endtask : rc

   // any other write between keys and target cancels the unlock
   task automatic uw(input logic [15:0] d);
      wr(OSW_OFS_UNLOCK, OSW_KEY_FIRST);
      wr(OSW_OFS_UNLOCK, OSW_KEY_SECOND);
      wr(OSW_OFS_OSC_CTRL, d);
   endtask : uw

   task automatic rst(input logic [8:0] c);
      reset <= 1'b1;
      cfg_i <= c;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : rst

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end

   initial begin
      reset = 1'b1;
      cfg_i = '1;
      switch_done_i = 1'b0;
      pll_locked_i = 1'b1;
      clock_fail_i = 1'b0;
      s_axi_awaddr = 4'h0;
      s_axi_araddr = 4'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h3;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      err_total = 0;
      checked = 0;
      cyc = 0;
      // erased fuses: divided mode, no switching, one-way pin lock
      rst(9'h1ff);
      rc("ctrl erased", OSW_OFS_OSC_CTRL, 16'h7700);
      rc("divider", OSW_OFS_CLK_DIV, 16'h0000);
      rc("cfg status erased", OSW_OFS_CFG_STAT, 16'h01ff);
      chk("monitor", {31'h0, ctrl_o.failsafe_clock_monitor}, 32'h0);
      chk("pin function", {31'h0, ctrl_o.osc_pin_function}, 32'h1);
      wr(OSW_OFS_OSC_CTRL, 16'h8f5e);
      rc("ctrl locked write", OSW_OFS_OSC_CTRL, 16'h7700);
      uw(16'h8f5e);
      rc("ctrl unlocked write", OSW_OFS_OSC_CTRL, 16'h7746);
      chk("ctrl out bits", {29'h0, ctrl_o.pin_config_lock, ctrl_o.primary_sleep_enable,
         ctrl_o.secondary_osc_enable}, 32'h7);
      uw(16'h0701);
      repeat (6) @(posedge clk);
      rc("ctrl no switch", OSW_OFS_OSC_CTRL, 16'h7740);
      chk("busy", {31'h0, ctrl_o.switch_busy}, 32'h0);
      $display("test 1 done");
      // monitor on, start on fast rc
      rst(9'h000);
      rc("ctrl fast rc", OSW_OFS_OSC_CTRL, 16'h0000);
      chk("monitor", {31'h0, ctrl_o.failsafe_clock_monitor}, 32'h1);
      rc("cfg status open", OSW_OFS_CFG_STAT, 16'h0600);
      uw(16'h0101);
      repeat (4) @(posedge clk);
      chk("busy", {31'h0, ctrl_o.switch_busy}, 32'h1);
      rc("ctrl pending", OSW_OFS_OSC_CTRL, 16'h0101);
      switch_done_i <= 1'b1;
      repeat (8) @(posedge clk);
      switch_done_i <= 1'b0;
      rc("ctrl switched", OSW_OFS_OSC_CTRL, 16'h1120);
      chk("sources out", {26'h0, ctrl_o.current_source, ctrl_o.requested_source}, 32'h9);
      clock_fail_i <= 1'b1;
      repeat (6) @(posedge clk);
      clock_fail_i <= 1'b0;
      rc("ctrl fail", OSW_OFS_OSC_CTRL, 16'h1128);
      uw(16'h0140);
      rc("ctrl pin lock", OSW_OFS_OSC_CTRL, 16'h1160);
      chk("pin lock out", {31'h0, ctrl_o.pin_config_lock}, 32'h1);
      uw(16'h0100);
      rc("ctrl fail clear", OSW_OFS_OSC_CTRL, 16'h1120);
      uw(16'h0180);
      uw(16'h0281);
      repeat (6) @(posedge clk);
      rc("ctrl sel locked", OSW_OFS_OSC_CTRL, 16'h11a0);
      $display("test 2 done");
      // switching on, monitor off, primary with driver mode 2
      rst(9'h0a8);
      chk("monitor", {31'h0, ctrl_o.failsafe_clock_monitor}, 32'h0);
      chk("driver mode", {30'h0, ctrl_o.primary_driver_mode}, 32'h2);
      uw(16'h0280);
      uw(16'h0381);
      repeat (4) @(posedge clk);
      switch_done_i <= 1'b1;
      repeat (8) @(posedge clk);
      switch_done_i <= 1'b0;
      rc("ctrl lock ignored", OSW_OFS_OSC_CTRL, 16'h33a0);
      clock_fail_i <= 1'b1;
      pll_locked_i <= 1'b0;
      repeat (6) @(posedge clk);
      clock_fail_i <= 1'b0;
      rc("ctrl unlocked pll", OSW_OFS_OSC_CTRL, 16'h3380);
      // upper byte strobe off: divider source must not move
      s_axi_wstrb <= 4'h1;
      wr(OSW_OFS_CLK_DIV, 16'h0700);
      s_axi_wstrb <= 4'h3;
      rc("divider kept", OSW_OFS_CLK_DIV, 16'h0000);
      wr(OSW_OFS_CLK_DIV, 16'h0500);
      rc("divider", OSW_OFS_CLK_DIV, 16'h0500);
      chk("divider out", {29'h0, ctrl_o.divider_source_select}, 32'h5);
      rc("unlock reg", OSW_OFS_UNLOCK, 16'h0000);
      $display("test 3 done");
      summarize();
   end
endmodule : osw_osc_switch_test

bind osw_osc_switch osw_osc_switch_chk i_chk (.clk(clk), .reset(reset), .cfg_i(cfg_i),
   .switch_done_i(switch_done_i), .ctrl_o(ctrl_o), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready));
